//--- rtl/udids_regs.svh
// Purpose: register map, field positions and timing constants of the irq/dma select block
// Assumes: byte addresses on a 32-bit AXI4-Lite bus
// Notes: definitions only
`ifndef UDIDS_REGS_SVH
`define UDIDS_REGS_SVH
`define UDIDS_ADDR_MAIN_STATUS 8'h18
`define UDIDS_ADDR_DMA_REASON 8'h50
`define UDIDS_ADDR_DMA_ENABLE 8'h54
`define UDIDS_ADDR_DMA_EP_SEL 8'h58
`define UDIDS_MAIN_MASK 32'h03ff_fd7f
`define UDIDS_DMA_MASK 16'h1ffe
`define UDIDS_EPSEL_MASK 8'h0f
`define UDIDS_BIT_BUS_RESET 0
`define UDIDS_BIT_SOF 1
`define UDIDS_BIT_PSEUDO_FRAME_TICK 2
`define UDIDS_BIT_SUSPEND 3
`define UDIDS_BIT_RESUME 4
`define UDIDS_BIT_HS_CHANGE 5
`define UDIDS_BIT_DMA 6
`define UDIDS_BIT_SETUP 8
`define UDIDS_BIT_EP_LO 10
`define UDIDS_BIT_DIR 0
`define UDIDS_EP_LSB 1
`define UDIDS_EP_MSB 3
`define UDIDS_FS_PERIOD_NS 1000000
`define UDIDS_HS_PERIOD_NS 125000
`define UDIDS_CLK_PERIOD_NS 10
`define UDIDS_RESP_OKAY 2'b00
`define UDIDS_RESP_SLVERR 2'b10
`endif

//--- rtl/udids_pkg.sv
// Purpose: shared types of the irq/dma select block
// Assumes: nothing beyond the register header
// Notes: constants live in udids_regs.svh
`default_nettype none
package udids_pkg;
    typedef logic [31:0] udids_word_type;
    typedef logic [2:0] udids_ep_type;
    typedef enum logic [1:0] {
        UDIDS_RD_IDLE = 2'b00,
        UDIDS_RD_RESP = 2'b01
    } udids_rd_state_type;
endpackage : udids_pkg
`default_nettype wire

//--- rtl/udids_pseudo_frame_tick_tick.sv
// Purpose: pseudo frame tick generator re-aligned to every frame start
// Assumes: sof pulse is one cycle, high_speed is a level
// Notes: parameters shorten the periods for simulation
`default_nettype none
`include "udids_regs.svh"
module udids_pseudo_frame_tick_tick #(
    parameter int FS_CYCLES = `UDIDS_FS_PERIOD_NS / `UDIDS_CLK_PERIOD_NS,
    parameter int HS_CYCLES = `UDIDS_HS_PERIOD_NS / `UDIDS_CLK_PERIOD_NS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sof_seen,
    input wire logic high_speed,
    output logic tick
);
    logic [16:0] count;
    logic [16:0] period;
    assign period = high_speed ? 17'(HS_CYCLES - 1) : 17'(FS_CYCLES - 1);
    ////////////////////////////////////////////////////////////////
    // tick synced to sof
    // a real sof restarts the count, so the tick follows bus timing
    always_ff @(posedge aclk) begin
        if (!aresetn || sof_seen) begin
            count <= 17'h0;
            tick <= 1'b0;
        end else if (count >= period) begin
            count <= 17'h0;
            tick <= 1'b1;
        end else begin
            count <= count + 17'h1;
            tick <= 1'b0;
        end
    end
endmodule : udids_pseudo_frame_tick_tick
`default_nettype wire

//--- rtl/udids_top.sv
// Purpose: main interrupt status, dma reason/enable and dma endpoint select behind AXI4-Lite
// Assumes: event inputs are one-cycle pulses synchronous to aclk
// Notes: the dma engine, endpoint fifos and task file logic live elsewhere
//
// Contract
// - an enabled dma reason bit raises the dma summary event
// - dma enable bits clear on power reset and bus reset
// - dma enable is 16 bits, bits 12..1 usable, others reserved
// - dma endpoint field bits 3..1 picks the dma endpoint fifo
// - direction zero connects rx/out fifo for dma reads
// - direction one connects tx/in fifo for dma writes
// - main interrupt status is a 32-bit register at its own address
// - status bits set on their event and hold until cleared
// - interrupt output high while any status bit set
// - endpoint tx/rx pairs in bits 25..10, tx at odd bit
// - bus state bits at 0..6 and 8; 7, 9, 31..26 reserved
// - dma reports through one summary bit; cause in reason register
// - write one clears a status bit, zero leaves it
// - reason bits update after dma command, write one clears
// - pseudo frame tick synced to sof, 1 ms fs, 125 us hs
//
// Our own choice: the AXI4-Lite slave port.
`default_nettype none
`include "udids_regs.svh"
module udids_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output udids_pkg::udids_word_type s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic usb_bus_reset_seen,
    input wire logic sof_seen,
    input wire logic suspend_entered,
    input wire logic resume_seen,
    input wire logic high_speed_change,
    input wire logic high_speed,
    input wire logic ctrl_setup_received,
    input wire logic [7:0] ep_tx_buffer_event,
    input wire logic [7:0] ep_rx_buffer_event,
    input wire logic dma_cmd_done,
    input wire logic [15:0] dma_reason_event,
    output logic irq,
    output udids_pkg::udids_ep_type dma_ep_number,
    output logic dma_direction,
    output logic dma_rx_fifo_sel,
    output logic dma_tx_fifo_sel
);
    import udids_pkg::*;

    logic [31:0] main_interrupt_status;
    logic [15:0] dma_interrupt_reason;
    logic [15:0] dma_interrupt_enable;
    logic [7:0] dma_endpoint_select;
    logic [31:0] next_main_set;
    logic pseudo_frame_tick;
    logic [7:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic do_write;
    logic [31:0] wr_mask;
    logic [31:0] strb_bits;
    logic dma_summary;
    logic dma_summary_q;
    logic soft_clear_ok;
    udids_rd_state_type rd_state;

    // byte enables widened to a bit mask
    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction : strb_mask

    // write-one-to-clear with set winning over a clear in the same cycle
    function automatic logic [31:0] w1c(input logic [31:0] cur, input logic [31:0] set,
                                        input logic [31:0] clr);
        w1c = (cur & ~clr) | set;
    endfunction : w1c

    ////////////////////////////////////////////////////////////////
    // pseudo frame tick
    udids_pseudo_frame_tick_tick u_pseudo_frame_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .sof_seen(sof_seen),
        .high_speed(high_speed),
        .tick(pseudo_frame_tick)
    );

    ////////////////////////////////////////////////////////////////
    // write channel capture; address and data may come in either order
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign strb_bits = strb_mask(w_strb);
    assign wr_mask = do_write ? (w_data & strb_bits) : 32'h0;
    assign soft_clear_ok = do_write;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    // write response one cycle after both halves are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `UDIDS_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            unique case (aw_addr)
                `UDIDS_ADDR_MAIN_STATUS, `UDIDS_ADDR_DMA_REASON,
                `UDIDS_ADDR_DMA_ENABLE, `UDIDS_ADDR_DMA_EP_SEL: begin
                    s_axi_bresp <= `UDIDS_RESP_OKAY;
                end
                default: begin
                    s_axi_bresp <= `UDIDS_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // reason update and clear
    always_ff @(posedge aclk) begin
        if (!aresetn || usb_bus_reset_seen) begin
            dma_interrupt_reason <= 16'h0;
        end else begin
            dma_interrupt_reason <= 16'(w1c({16'h0, dma_interrupt_reason},
                {16'h0, (dma_cmd_done ? dma_reason_event : 16'h0) & `UDIDS_DMA_MASK},
                (soft_clear_ok && aw_addr == `UDIDS_ADDR_DMA_REASON) ? wr_mask : 32'h0));
        end
    end

    ////////////////////////////////////////////////////////////////
    // enable cleared on both resets
    always_ff @(posedge aclk) begin
        if (!aresetn || usb_bus_reset_seen) begin
            dma_interrupt_enable <= 16'h0;
        end else if (do_write && aw_addr == `UDIDS_ADDR_DMA_ENABLE) begin
            dma_interrupt_enable <= (dma_interrupt_enable & ~strb_bits[15:0])
                | (w_data[15:0] & strb_bits[15:0] & `UDIDS_DMA_MASK);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || usb_bus_reset_seen) begin
            dma_endpoint_select <= 8'h0;
        end else if (do_write && aw_addr == `UDIDS_ADDR_DMA_EP_SEL && w_strb[0]) begin
            dma_endpoint_select <= w_data[7:0] & `UDIDS_EPSEL_MASK;
        end
    end

    assign dma_ep_number = dma_endpoint_select[`UDIDS_EP_MSB:`UDIDS_EP_LSB];
    assign dma_direction = dma_endpoint_select[`UDIDS_BIT_DIR];
    assign dma_rx_fifo_sel = !dma_endpoint_select[`UDIDS_BIT_DIR];
    assign dma_tx_fifo_sel = dma_endpoint_select[`UDIDS_BIT_DIR];

    ////////////////////////////////////////////////////////////////
    // enabled reasons form the summary
    // edge of summary sets the single dma bit
    assign dma_summary = |(dma_interrupt_reason & dma_interrupt_enable);

    always_ff @(posedge aclk) begin
        if (!aresetn || usb_bus_reset_seen) begin
            dma_summary_q <= 1'b0;
        end else begin
            dma_summary_q <= dma_summary;
        end
    end

    always_comb begin
        next_main_set = 32'h0;
        next_main_set[`UDIDS_BIT_BUS_RESET] = usb_bus_reset_seen;
        next_main_set[`UDIDS_BIT_SOF] = sof_seen;
        next_main_set[`UDIDS_BIT_PSEUDO_FRAME_TICK] = pseudo_frame_tick;
        next_main_set[`UDIDS_BIT_SUSPEND] = suspend_entered;
        next_main_set[`UDIDS_BIT_RESUME] = resume_seen;
        next_main_set[`UDIDS_BIT_HS_CHANGE] = high_speed_change;
        next_main_set[`UDIDS_BIT_DMA] = dma_summary && !dma_summary_q;
        next_main_set[`UDIDS_BIT_SETUP] = ctrl_setup_received;
        for (int i = 0; i < 8; i++) begin
            next_main_set[`UDIDS_BIT_EP_LO + 2 * i] = ep_rx_buffer_event[i];
            next_main_set[`UDIDS_BIT_EP_LO + 2 * i + 1] = ep_tx_buffer_event[i];
        end
    end

    // bus reset clears all but keeps event bits of the same cycle, its own included
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            main_interrupt_status <= 32'h0;
        end else if (usb_bus_reset_seen) begin
            main_interrupt_status <= next_main_set & `UDIDS_MAIN_MASK;
        end else begin
            main_interrupt_status <= w1c(main_interrupt_status,
                next_main_set & `UDIDS_MAIN_MASK,
                (aw_addr == `UDIDS_ADDR_MAIN_STATUS) ? wr_mask : 32'h0);
        end
    end

    assign irq = |main_interrupt_status;

    ////////////////////////////////////////////////////////////////
    // read channel; map with reserved bits zero
    assign s_axi_arready = (rd_state == UDIDS_RD_IDLE);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state <= UDIDS_RD_IDLE;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `UDIDS_RESP_OKAY;
        end else begin
            unique case (rd_state)
                UDIDS_RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        rd_state <= UDIDS_RD_RESP;
                        s_axi_rresp <= `UDIDS_RESP_OKAY;
                        unique case (s_axi_araddr)
                            `UDIDS_ADDR_MAIN_STATUS: s_axi_rdata <= main_interrupt_status;
                            `UDIDS_ADDR_DMA_REASON: s_axi_rdata <= {16'h0, dma_interrupt_reason};
                            `UDIDS_ADDR_DMA_ENABLE: s_axi_rdata <= {16'h0, dma_interrupt_enable};
                            `UDIDS_ADDR_DMA_EP_SEL: s_axi_rdata <= {24'h0, dma_endpoint_select};
                            default: begin
                                s_axi_rdata <= 32'h0;
                                s_axi_rresp <= `UDIDS_RESP_SLVERR;
                            end
                        endcase
                    end
                end
                UDIDS_RD_RESP: begin
                    if (s_axi_rready) begin
                        rd_state <= UDIDS_RD_IDLE;
                    end
                end
                default: begin
                    rd_state <= UDIDS_RD_IDLE;
                end
            endcase
        end
    end
    assign s_axi_rvalid = (rd_state == UDIDS_RD_RESP);

    ////////////////////////////////////////////////////////////////
    // checks
    sequence dma_rise_s;
        dma_summary && !dma_summary_q && !usb_bus_reset_seen;
    endsequence

    dma_summary_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        dma_rise_s |=> main_interrupt_status[`UDIDS_BIT_DMA])
        else $error("dma summary bit not set");
    irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
        irq == (main_interrupt_status != 32'h0))
        else $error("irq does not follow status");
    status_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (main_interrupt_status[`UDIDS_BIT_SOF] && !do_write && !usb_bus_reset_seen)
        |=> main_interrupt_status[`UDIDS_BIT_SOF])
        else $error("status bit lost without clear");
    event_sets_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ep_tx_buffer_event[7] |=> main_interrupt_status[25])
        else $error("ep7 tx bit not set");
    reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (main_interrupt_status & ~`UDIDS_MAIN_MASK) == 32'h0
        && (dma_interrupt_enable & ~`UDIDS_DMA_MASK) == 16'h0)
        else $error("reserved bit set");
    bus_reset_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        usb_bus_reset_seen |=> dma_interrupt_enable == 16'h0 && dma_endpoint_select == 8'h0)
        else $error("bus reset did not clear");
    dir_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
        dma_rx_fifo_sel != dma_tx_fifo_sel && dma_tx_fifo_sel == dma_direction)
        else $error("fifo direction wrong");
    w1c_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (do_write && aw_addr == `UDIDS_ADDR_MAIN_STATUS && wr_mask[1] && !sof_seen
         && !usb_bus_reset_seen) |=> !main_interrupt_status[`UDIDS_BIT_SOF])
        else $error("write one did not clear");
    masked_reason_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (dma_interrupt_enable == 16'h0) |-> !dma_summary)
        else $error("disabled reason raised summary");
endmodule : udids_top
`default_nettype wire

//--- dv/udids_host_model.sv
// Purpose: axi4-lite host standing in for the processor that services the block
// Assumes: readies and valids are sampled at the rising edge, payload held until taken
// Notes: stuck rises when a handshake never completes within the bound
`default_nettype none
module udids_host_model (
    input wire logic aclk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire udids_pkg::udids_word_type rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready,
    output logic stuck
);
    timeunit 1ns;
    timeprecision 1ps;
    import udids_pkg::*;

    // idle bus at time zero
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready, stuck} = '0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // firmware register access path
    // one write at a time; released payload is inverted so stale values never match
    task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~d;
            end
            n++;
        end while (!(bvalid && bready) && n < 200);
        r = bresp;
        bready <= 1'b0;
        if (n >= 200) stuck = 1'b1;
    endtask : write

    task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
            n++;
        end while (!(rvalid && rready) && n < 200);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n >= 200) stuck = 1'b1;
    endtask : read
endmodule : udids_host_model
`default_nettype wire

//--- dv/usb_dev_irq_and_dma_ep_select_tb_top.sv
// Purpose: register level bench of the irq aggregation and dma endpoint select block
// Assumes: events are one-cycle pulses; high_speed held so the frame tick is 12500 cycles
// Notes: all tests before the tick test finish well inside one tick period
`default_nettype none
`include "udids_regs.svh"
module usb_dev_irq_and_dma_ep_select_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import udids_pkg::*;
    localparam logic [7:0] a_stat = `UDIDS_ADDR_MAIN_STATUS;
    localparam logic [7:0] a_rsn = `UDIDS_ADDR_DMA_REASON;
    localparam logic [7:0] a_en = `UDIDS_ADDR_DMA_ENABLE;
    localparam logic [7:0] a_sel = `UDIDS_ADDR_DMA_EP_SEL;
    localparam logic [1:0] ok = `UDIDS_RESP_OKAY;
    localparam logic [31:0] ev_bits = 32'h03ff_fd3a;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, stuck, irq, high_speed, dma_cmd_done;
    logic dma_direction, rx_sel, tx_sel;
    logic [7:0] awaddr, araddr, ep_tx, ep_rx;
    logic [31:0] wdata, ev, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [15:0] dma_reason_event;
    udids_word_type rdata;
    udids_ep_type dma_ep_number;
    int failures = 0;
    int num_checks = 0;
    int n;

    udids_top i_udids_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .usb_bus_reset_seen(ev[0]), .sof_seen(ev[1]),
        .suspend_entered(ev[3]), .resume_seen(ev[4]), .high_speed_change(ev[5]),
        .high_speed(high_speed), .ctrl_setup_received(ev[8]), .ep_tx_buffer_event(ep_tx),
        .ep_rx_buffer_event(ep_rx), .dma_cmd_done(dma_cmd_done),
        .dma_reason_event(dma_reason_event), .irq(irq), .dma_ep_number(dma_ep_number),
        .dma_direction(dma_direction), .dma_rx_fifo_sel(rx_sel), .dma_tx_fifo_sel(tx_sel));
    udids_host_model i_udids_host_model (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .stuck(stuck));

    // endpoint pair layout
    // rx of endpoint i sits at status bit 10+2i, tx one above it
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            ep_tx[i] = ev[11 + 2 * i];
            ep_rx[i] = ev[10 + 2 * i];
        end
    end

    // 100 MHz clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d, failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("unexpected %s: expected %h, seen %h", what, e, g);
            failures++;
        end
    endtask : check

    // a hung handshake is a mismatch and ends the run at once
    task automatic hung();
        if (stuck) begin
            failures++;
            close_out();
        end
    endtask : hung

    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        logic [1:0] br;
        i_udids_host_model.write(a, v, br);
        hung();
        check("bresp", {30'h0, er}, {30'h0, br});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
        logic [31:0] v;
        logic [1:0] rr;
        i_udids_host_model.read(a, v, rr);
        hung();
        check("rresp", {30'h0, ok}, {30'h0, rr});
        check(what, e, v);
    endtask : rd

    // events change just after an edge, so the design samples them a full cycle
    task automatic pulse(input logic [31:0] m);
        @(posedge aclk);
        ev <= m;
        @(posedge aclk);
        ev <= '0;
    endtask : pulse

    task automatic dma_pulse(input logic [15:0] m);
        @(posedge aclk);
        dma_cmd_done <= 1'b1;
        dma_reason_event <= m;
        @(posedge aclk);
        dma_cmd_done <= 1'b0;
        dma_reason_event <= '0;
    endtask : dma_pulse

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {aresetn, ev, dma_cmd_done, dma_reason_event} = '0;
        high_speed = 1'b1;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(a_stat, 32'h0, "status at reset");
        rd(a_en, 32'h0, "enable at reset");
        rd(a_sel, 32'h0, "ep select at reset");
        for (int b = 1; b < 26; b++) begin
            if (ev_bits[b]) begin
                pulse(32'h1 << b);
                rd(a_stat, 32'h1 << b, "single event bit");
                check("irq raised", 32'h1, {31'h0, irq});
                wr(a_stat, 32'hffff_ffff, ok);
            end
        end
        pulse(ev_bits);
        repeat (6) @(posedge aclk);
        rd(a_stat, ev_bits, "held events");
        wr(a_stat, 32'hfc00_0f00, ok);
        rd(a_stat, ev_bits & ~32'h0000_0f00, "partial clear");
        wr(a_stat, 32'h0, ok);
        rd(a_stat, ev_bits & ~32'h0000_0f00, "zero write");
        wr(a_stat, 32'hffff_ffff, ok);
        check("irq low", 32'h0, {31'h0, irq});
        wr(a_en, 32'hffff_ffff, ok);
        rd(a_en, 32'h0000_1ffe, "enable width");
        dma_pulse(16'h0002);
        rd(a_rsn, 32'h2, "reason bit");
        rd(a_stat, 32'h40, "dma summary");
        wr(a_rsn, 32'h2, ok);
        wr(a_stat, 32'h40, ok);
        rd(a_stat, 32'h0, "dma cleared");
        rd(a_rsn, 32'h0, "reason cleared");
        wr(a_en, 32'h0000_1fee, ok);
        dma_pulse(16'he011);
        rd(a_rsn, 32'h10, "reason reserved");
        rd(a_stat, 32'h0, "masked source");
        wr(a_rsn, 32'h10, ok);
        // every select value 0..15 is decoded in turn and dma ends parked on 7
        for (int i = 0; i < 16; i++) begin
            wr(a_sel, 32'hffff_fff0 | 32'(i), ok);
            rd(a_sel, 32'(i), "ep select");
            check("dma ep", 32'(i >> 1), {29'h0, dma_ep_number});
            check("direction", 32'(i & 1), {31'h0, dma_direction});
            check("rx fifo", 32'(~i & 1), {31'h0, rx_sel});
            check("tx fifo", 32'(i & 1), {31'h0, tx_sel});
        end
        i_udids_host_model.read(8'h20, d, r);
        hung();
        check("unmapped data", 32'h0, d);
        check("unmapped rresp", 32'h2, {30'h0, r});
        wr(8'h20, 32'hffff_ffff, `UDIDS_RESP_SLVERR);
        wr(a_en, 32'h0000_1ffe, ok);
        pulse(32'h0200_0002);
        pulse(32'h1);
        rd(a_stat, 32'h1, "after bus reset");
        rd(a_en, 32'h0, "enable after bus reset");
        rd(a_sel, 32'h0, "select after bus reset");
        check("dma ep after bus reset", 32'h0, {29'h0, dma_ep_number});
        // tick lands one period after the last frame start
        pulse(32'h2);
        wr(a_stat, 32'hffff_ffff, ok);
        n = 0;
        while (irq !== 1'b1 && n < 13000) begin
            @(posedge aclk);
            n++;
        end
        check("tick period", 32'h1, {31'h0, n > 12400 && n < 12510});
        rd(a_stat, 32'h4, "pseudo frame tick");
        close_out();
    end
endmodule : usb_dev_irq_and_dma_ep_select_tb_top
`default_nettype wire
